// File: core/sism_top.sv
// Interrupt status and mask logic of the pressure sensor core.
// Assumes event strobes and the queue fill level come from logic
// on mclk_i, so no synchronisers are needed on them.
`default_nettype none

module sism_top (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // event strobes from the measurement path
  input  wire logic       delta_evt_i,
  input  wire logic       abs_evt_i,
  input  wire logic       underflow_evt_i,
  input  wire logic       overflow_evt_i,
  // queue fill level
  input  wire logic [4:0] queue_level_i,
  // watermark settings out to the queue
  output logic      [3:0] queue_high_level_setting_o,
  output logic      [3:0] queue_low_level_setting_o,
  // interrupt
  output logic            irq_o
);

  ////////////////////////////////////////////////////////////////////
  // state
  sism_pkg::sism_state_t q;
  sism_pkg::sism_state_t d;

  ////////////////////////////////////////////////////////////////////
  // watermark fields
  logic [sism_pkg::WM_W-1:0]    wm_high;
  logic [sism_pkg::WM_W-1:0]    wm_low;
  logic [sism_pkg::LEVEL_W-1:0] wm_high_ext;
  logic [sism_pkg::LEVEL_W-1:0] wm_low_ext;

  assign wm_high =
    q.queue_cfg[sism_pkg::QCFG_HIGH_LSB +: sism_pkg::WM_W];
  assign wm_low  =
    q.queue_cfg[sism_pkg::QCFG_LOW_LSB +: sism_pkg::WM_W];
  assign wm_high_ext = {1'b0, wm_high};
  assign wm_low_ext  = {1'b0, wm_low};

  ////////////////////////////////////////////////////////////////////
  // watermark crossings
  // only a change of level in the right direction counts, so a
  // level that sits on the watermark raises the flag once
  logic level_up;
  logic level_down;
  logic low_hit;
  logic high_hit;

  assign level_up   = queue_level_i > q.level_prev;
  assign level_down = queue_level_i < q.level_prev;

  assign low_hit  = level_down
                  && (queue_level_i == wm_low_ext);
  assign high_hit = level_up
                  && (queue_level_i == wm_high_ext)
                  && (wm_high != 4'h0);

  ////////////////////////////////////////////////////////////////////
  // event vector in flag layout
  logic [7:0] evt;

  always_comb begin
    evt = 8'h00;
    evt[sism_pkg::BIT_DELTA]     = delta_evt_i;
    evt[sism_pkg::BIT_ABS]       = abs_evt_i;
    evt[sism_pkg::BIT_LOW_WM]    = low_hit;
    evt[sism_pkg::BIT_HIGH_WM]   = high_hit;
    evt[sism_pkg::BIT_UNDERFLOW] = underflow_evt_i;
    evt[sism_pkg::BIT_OVERFLOW]  = overflow_evt_i;
  end

  ////////////////////////////////////////////////////////////////////
  // register decode
  logic wr_flags;
  logic wr_masks;
  logic wr_qcfg;

  assign wr_flags = reg_wr_i
                  && (reg_addr_i == sism_pkg::ADDR_FLAGS);
  assign wr_masks = reg_wr_i
                  && (reg_addr_i == sism_pkg::ADDR_MASKS);
  assign wr_qcfg  = reg_wr_i
                  && (reg_addr_i == sism_pkg::ADDR_QUEUECFG);

  // write-one-to-clear pattern for the flags
  logic [7:0] clr;

  assign clr = wr_flags ? reg_wdata_i : 8'h00;

  ////////////////////////////////////////////////////////////////////
  // per-bit sticky flags
  // set wins over clear so an event in the clearing cycle survives
  logic [7:0] flags_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      if (sism_pkg::FLAGS_IMPL[gi]) begin : g_impl
        assign flags_nxt[gi] = evt[gi]
                             | (q.flags[gi] & ~clr[gi]);
      end else begin : g_rsvd
        assign flags_nxt[gi] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // mask register
  // bit 7 is kept as written; the host is expected to set it
  logic [7:0] masks_nxt;

  always_comb begin
    masks_nxt = q.masks;
    if (wr_masks) begin
      masks_nxt = reg_wdata_i & sism_pkg::MASKS_IMPL;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt level
  // computed from next-state values so the registered output
  // follows the flags with no extra cycle
  logic [7:0] pending;
  logic       irq_nxt;

  assign pending = flags_nxt & ~masks_nxt
                 & sism_pkg::SRC_IMPL;
  assign irq_nxt = |pending;

  ////////////////////////////////////////////////////////////////////
  // read mux
  logic [7:0] rd_val;

  always_comb begin
    case (reg_addr_i)
      sism_pkg::ADDR_FLAGS: begin
        rd_val = q.flags & sism_pkg::FLAGS_IMPL;
      end
      sism_pkg::ADDR_MASKS: begin
        rd_val = q.masks & sism_pkg::MASKS_IMPL;
      end
      sism_pkg::ADDR_QUEUECFG: begin
        rd_val = q.queue_cfg;
      end
      default: begin
        rd_val = sism_pkg::RD_UNMAPPED;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    d.flags      = flags_nxt;
    d.masks      = masks_nxt;
    d.level_prev = queue_level_i;
    d.irq        = irq_nxt;
    // read data stands for one cycle only
    d.rdata      = 8'h00;
    if (reg_rd_i) begin
      d.rdata = rd_val;
    end
    if (wr_qcfg) begin
      d.queue_cfg = reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      q.flags      <= sism_pkg::RST_FLAGS;
      q.masks      <= sism_pkg::RST_MASKS;
      q.queue_cfg  <= sism_pkg::RST_QUEUECFG;
      q.level_prev <= sism_pkg::RST_LEVEL;
      q.rdata      <= sism_pkg::RD_UNMAPPED;
      q.irq        <= 1'b0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata_o                = q.rdata;
  assign irq_o                      = q.irq;
  assign queue_high_level_setting_o = wm_high;
  assign queue_low_level_setting_o  = wm_low;

endmodule : sism_top

`default_nettype wire

// File: core/sism_pkg.sv
// Constants and state type of the interrupt status and mask block.
// Assumes one clock, a synchronous active-low reset and an 8-bit
// register port with read data one cycle after the read strobe.
//
// Contract
// - delta-pressure event sets status bit 6.
// - absolute-pressure threshold crossing sets status bit 5.
// - fill level falling to the low watermark sets status bit 3.
// - fill level rising to the high watermark sets status bit 2.
// - fetch from an empty queue sets status bit 1.
// - write into a full queue sets status bit 0.
// - a flag stays set until the host writes one; zero leaves it.
// - mask bit one masks its source; bits 6,5,3,2,1,0 as status.
// - high watermark of zero disables the high watermark flag.
// - high watermark is config bits 7:4, low watermark bits 3:0.
`default_nettype none

package sism_pkg;

  ////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] ADDR_FLAGS    = 8'hC1;
  localparam logic [7:0] ADDR_MASKS    = 8'hC2;
  localparam logic [7:0] ADDR_QUEUECFG = 8'hC3;

  // reset values
  localparam logic [7:0] RST_FLAGS     = 8'h00;
  localparam logic [7:0] RST_MASKS     = 8'h00;
  localparam logic [7:0] RST_QUEUECFG  = 8'h00;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;
  localparam logic [4:0] RST_LEVEL     = 5'h00;

  ////////////////////////////////////////////////////////////////////
  // flag and mask bit positions
  localparam int BIT_DELTA     = 6;
  localparam int BIT_ABS       = 5;
  localparam int BIT_LOW_WM    = 3;
  localparam int BIT_HIGH_WM   = 2;
  localparam int BIT_UNDERFLOW = 1;
  localparam int BIT_OVERFLOW  = 0;

  // bits that hold state; others read zero
  localparam logic [7:0] FLAGS_IMPL = 8'h6F;
  localparam logic [7:0] MASKS_IMPL = 8'hEF;
  localparam logic [7:0] SRC_IMPL   = 8'h6F;

  // queue configuration fields
  localparam int QCFG_HIGH_LSB = 4;
  localparam int QCFG_LOW_LSB  = 0;
  localparam int WM_W          = 4;
  localparam int LEVEL_W       = 5;

  ////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]         flags;
    logic [7:0]         masks;
    logic [7:0]         queue_cfg;
    logic [LEVEL_W-1:0] level_prev;
    logic [7:0]         rdata;
    logic               irq;
  } sism_state_t;

endpackage : sism_pkg

`default_nettype wire

// File: sim/sism_properties.sv
// assertions on the ports of sism_top
// bound from the bench; one clock, synchronous active-low reset
`default_nettype none
module sism_properties (
  input wire logic       mclk_i, nrst_i, reg_wr_i, reg_rd_i, irq_o,
  input wire logic       delta_evt_i, abs_evt_i,
  input wire logic       underflow_evt_i, overflow_evt_i,
  input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
  input wire logic [4:0] queue_level_i,
  input wire logic [3:0] queue_high_level_setting_o,
  input wire logic [3:0] queue_low_level_setting_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence rd_flags;
    reg_rd_i && reg_addr_i == 8'hC1;
  endsequence
  // no clearing write may fall between event and read
  property evt_kept(e, b);
    e ##1 !reg_wr_i ##1 rd_flags |=> reg_rdata_o[b];
  endproperty
  a_delta_flag: assert property (evt_kept(delta_evt_i, 6))
    else $error("delta event flag missing");
  a_abs_flag: assert property (evt_kept(abs_evt_i, 5))
    else $error("threshold event flag missing");
  a_under_flag: assert property (evt_kept(underflow_evt_i, 1))
    else $error("underflow flag missing");
  a_over_flag: assert property (evt_kept(overflow_evt_i, 0))
    else $error("overflow flag missing");
  a_rsvd_zero: assert property (rd_flags |=>
    !reg_rdata_o[7] && !reg_rdata_o[4])
    else $error("reserved flag bits not zero");
  a_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 8'hC1 ||
    reg_addr_i > 8'hC3) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_wm_load: assert property (reg_wr_i && reg_addr_i == 8'hC3 |=>
    {queue_high_level_setting_o, queue_low_level_setting_o}
    == $past(reg_wdata_i)) else $error("watermark setting not loaded");
  a_irq_cause: assert property ($rose(irq_o) |-> $past(reg_wr_i ||
    delta_evt_i || abs_evt_i || underflow_evt_i || overflow_evt_i)
    || $past(queue_level_i) != $past(queue_level_i, 2))
    else $error("interrupt rose without cause");
  a_irq_clear: assert property ($fell(irq_o) |-> $past(reg_wr_i))
    else $error("interrupt fell without a write");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data stood beyond one cycle");
endmodule : sism_properties
`default_nettype wire

// File: sim/sism_host.sv
// host side of the register port: single reads and writes
// drives right after a rising edge of mclk_i
`default_nettype none
module sism_host (
  input  wire logic       mclk_i,
  input  wire logic [7:0] reg_rdata_i,
  output var  logic [7:0] reg_addr_o, reg_wdata_o,
  output var  logic       reg_wr_o, reg_rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = 18'h00000;
  // released lines show inverted values, never the last ones, except data bit 7 after a mask write with d bit 7 clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_o <= a;
    reg_wdata_o <= (a == 8'hC2) ? (d | 8'h80) : d;
    reg_wr_o <= 1'b1;
    @(posedge mclk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge mclk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(negedge mclk_i);
    d = reg_rdata_i;
  endtask : rd
endmodule : sism_host
`default_nettype wire

// File: sim/sism_top_bench.sv
// self-checking bench of sism_top; host model drives the registers
// an integer model predicts flags, masks and irq_o
`default_nettype none
module sism_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic       hwr, hrd, irq;
  logic       dlt = 1'b0, ab = 1'b0, und = 1'b0, ovf = 1'b0;
  logic [4:0] lvl = 5'h00;
  logic [3:0] hi_o, lo_o;
  logic [15:0] rnd = 16'h2DA0;
  int fails = 0, checks_done = 0, flags = 0, masks = 0, prev = 0, cfg = 0;
  int lv[9] = '{4, 3, 2, 7, 8, 16, 9, 0, 3};
  logic [7:0] cf[2] = '{8'h83, 8'h03};
  always #25 mclk_i = ~mclk_i;
  sism_top dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(hwr), .reg_rd_i(hrd),
    .reg_rdata_o(rdata), .delta_evt_i(dlt), .abs_evt_i(ab),
    .underflow_evt_i(und), .overflow_evt_i(ovf), .queue_level_i(lvl),
    .queue_high_level_setting_o(hi_o), .queue_low_level_setting_o(lo_o),
    .irq_o(irq));
  sism_host host_u (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(hwr), .reg_rd_o(hrd));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk("register read", e, d);
    chk("irq_o", 8'((flags & ~masks) != 0), {7'h00, irq});
  endtask : rd_chk
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    host_u.wr(a, d);
    if (a == 8'hC1) flags &= ~int'(d);
    if (a == 8'hC2) masks = (d | 8'h80) & 8'hEF;
    if (a == 8'hC3) cfg = d;
    @(negedge mclk_i);
  endtask : reg_wr
  task automatic pulse(input logic [3:0] v);
    @(posedge mclk_i);
    {dlt, ab, und, ovf} <= v;
    @(posedge mclk_i);
    {dlt, ab, und, ovf} <= 4'h0;
    flags |= {v[3:2], 3'b000, v[1:0]};
  endtask : pulse
  task automatic level(input int v);
    @(posedge mclk_i);
    lvl <= 5'(v);
    if (v < prev && v == cfg % 16) flags |= 8;
    if (v > prev && v == cfg / 16 && cfg >= 16) flags |= 4;
    prev = v;
  endtask : level
  task automatic end_sim;
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (3000) @(posedge mclk_i);
    fails++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd_chk(8'hC1, 8'h00);
    rd_chk(8'hC2, 8'h00);
    rd_chk(8'hC3, 8'h00);
    reg_wr(8'hC0, 8'hFF);
    rd_chk(8'hC0, 8'h00);
    for (int i = 0; i < 60; i++) begin
      rnd = lfsr(rnd);
      pulse(rnd[3:0]);
      rd_chk(8'hC1, 8'(flags));
      if (rnd[4]) reg_wr(8'hC2, rnd[15:8]);
      if (rnd[5]) reg_wr(8'hC1, rnd[11:4]);
      rd_chk(8'hC2, 8'(masks));
    end
    // events and a full clear on one edge: the events must survive
    fork
      pulse(4'hF);
      host_u.wr(8'hC1, 8'hFF);
    join
    flags = 8'h63;
    rd_chk(8'hC1, 8'(flags));
    foreach (cf[k]) begin
      reg_wr(8'hC1, 8'hFF);
      reg_wr(8'hC3, cf[k]);
      chk("watermark settings", cf[k], {hi_o, lo_o});
      foreach (lv[j]) begin
        level(lv[j]);
        rd_chk(8'hC1, 8'(flags));
      end
    end
    end_sim();
  end
endmodule : sism_top_bench
bind sism_top sism_properties chk_u (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .irq_o(irq_o),
  .delta_evt_i(delta_evt_i), .abs_evt_i(abs_evt_i),
  .underflow_evt_i(underflow_evt_i), .overflow_evt_i(overflow_evt_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .queue_level_i(queue_level_i),
  .queue_high_level_setting_o(queue_high_level_setting_o),
  .queue_low_level_setting_o(queue_low_level_setting_o));
`default_nettype wire
